// ==== common/pcb_defs.svh ====
// Purpose: constants of the configuration register bank
// Assumes: byte addresses, one 32-bit word per register
// Notes: masks mark host-writable bits
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH
`define PCB_OFS_ID 8'h00
`define PCB_OFS_CMD 8'h04
`define PCB_OFS_CLASS 8'h08
`define PCB_OFS_LAT 8'h0c
`define PCB_OFS_IO 8'h10
`define PCB_OFS_MEM 8'h14
`define PCB_OFS_SUB 8'h2c
`define PCB_OFS_ROM 8'h30
`define PCB_OFS_CAPP 8'h34
`define PCB_OFS_INT 8'h3c
`define PCB_OFS_SCRATCH 8'h40
`define PCB_OFS_FPRINT 8'h80
`define PCB_OFS_PMC 8'hc0
`define PCB_OFS_PMCS 8'hc4
`define PCB_MSK_CMD 32'h0000_0147
`define PCB_MSK_LAT 32'h0000_ffff
`define PCB_MSK_IO 32'hffff_ff00
`define PCB_MSK_MEM 32'hffff_ff00
`define PCB_MSK_ROM 32'hfffe_0001
`define PCB_MSK_INT 32'h0000_00ff
`define PCB_MSK_SCRATCH 32'h0000_ff00
`define PCB_MSK_PMCS 32'h0000_0103
`define PCB_STS_PERR 31
`define PCB_STS_SERR 30
`define PCB_STS_MABT 29
`define PCB_STS_TABT 28
`define PCB_STS_DPR 24
`define PCB_CMD_PERR_EN 6
`define PCB_STS_FIXED 16'h0280
`define PCB_STS_NEWCAP 20
`define PCB_IO_IND 32'h0000_0001
`define PCB_CAP_ID 8'h01
`define PCB_NEXT_PTR 8'h00
`define PCB_INT_PIN 8'h01
`define PCB_ZERO 32'h0000_0000
`endif

// ==== common/pcb_pkg.sv ====
// Purpose: types of the configuration register bank
// Assumes: nothing
// Notes: load sequencer states
package pcb_pkg;
  typedef enum logic [0:0] {LD_FETCH, LD_DONE} pcb_ld_e;
  typedef logic [31:0] pcb_word_t;
endpackage

// ==== src/pcb_cfg_bank.sv ====
// Purpose: configuration register bank of an Ethernet controller
// Assumes: word-aligned addresses, byte enables per lane
// Notes: ID fields come from the serial EEPROM loader after reset
`include "pcb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pcb_cfg_bank
  import pcb_pkg::*;
#(
  parameter logic [23:0] CLASS_CODE = 24'h020000,
  parameter logic [7:0] REV_STEP = 8'h00,
  // Arbitrary value
  parameter logic [31:0] SIGNATURE = 32'h5a5a_0001,
  parameter logic [15:0] PM_CAPS = 16'h0002,
  parameter logic NEW_CAP = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] BE,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic EE_ACK,
  input wire logic [15:0] EE_DEV_ID,
  input wire logic [15:0] EE_VEN_ID,
  input wire logic [15:0] EE_SUB_ID,
  input wire logic [15:0] EE_SUBVEN_ID,
  input wire logic [7:0] EE_MAX_LAT,
  input wire logic [7:0] EE_MIN_GNT,
  output logic EE_REQ,
  output logic LOAD_DONE,
  input wire logic PERR_DET,
  input wire logic SERR_DRV,
  input wire logic MABT_DET,
  input wire logic TABT_DET,
  input wire logic BUS_MASTER,
  output logic [15:0] CMD,
  output logic [1:0] PM_STATE
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release; soft reset never reaches this bank
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  function automatic pcb_word_t merge(input pcb_word_t old, input pcb_word_t wd,
                                      input logic [3:0] be, input pcb_word_t msk);
    pcb_word_t lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~(lane & msk)) | (wd & lane & msk);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // EEPROM load sequencer
  pcb_ld_e ld_r, ld_nxt;
  logic [15:0] dev_r, dev_nxt, ven_r, ven_nxt, sub_r, sub_nxt, subv_r, subv_nxt;
  logic [7:0] mlat_r, mlat_nxt, mgnt_r, mgnt_nxt;

  always_comb begin
    ld_nxt = ld_r;
    dev_nxt = dev_r;
    ven_nxt = ven_r;
    sub_nxt = sub_r;
    subv_nxt = subv_r;
    mlat_nxt = mlat_r;
    mgnt_nxt = mgnt_r;
    unique case (ld_r)
      LD_FETCH: begin
        if (EE_ACK) begin
          ld_nxt = LD_DONE;
          dev_nxt = EE_DEV_ID;
          ven_nxt = EE_VEN_ID;
          sub_nxt = EE_SUB_ID;
          subv_nxt = EE_SUBVEN_ID;
          mlat_nxt = EE_MAX_LAT;
          mgnt_nxt = EE_MIN_GNT;
        end
      end
      LD_DONE: begin
        ld_nxt = LD_DONE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ld_r <= LD_FETCH;
      dev_r <= 16'h0;
      ven_r <= 16'h0;
      sub_r <= 16'h0;
      subv_r <= 16'h0;
      mlat_r <= 8'h0;
      mgnt_r <= 8'h0;
      EE_REQ <= 1'b0;
      LOAD_DONE <= 1'b0;
    end else begin
      ld_r <= ld_nxt;
      dev_r <= dev_nxt;
      ven_r <= ven_nxt;
      sub_r <= sub_nxt;
      subv_r <= subv_nxt;
      mlat_r <= mlat_nxt;
      mgnt_r <= mgnt_nxt;
      EE_REQ <= (ld_nxt == LD_FETCH);
      LOAD_DONE <= (ld_nxt == LD_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable registers
  logic [7:0] wa;
  pcb_word_t cmd_r, cmd_nxt, lat_r, lat_nxt, io_r, io_nxt, mem_r, mem_nxt;
  pcb_word_t rom_r, rom_nxt, int_r, int_nxt, scratch_r, scratch_nxt, pmcs_r, pmcs_nxt;
  logic [4:0] sts_r, sts_nxt;
  logic [4:0] sts_set, sts_clr;

  assign wa = {ADDR[7:2], 2'b00};

  always_comb begin
    cmd_nxt = cmd_r;
    lat_nxt = lat_r;
    io_nxt = io_r;
    mem_nxt = mem_r;
    rom_nxt = rom_r;
    int_nxt = int_r;
    scratch_nxt = scratch_r;
    pmcs_nxt = pmcs_r;
    sts_clr = 5'h0;
    // Parity flag ignores the enable bit; report needs it
    sts_set = {PERR_DET, SERR_DRV, MABT_DET, TABT_DET,
               PERR_DET & BUS_MASTER & cmd_r[`PCB_CMD_PERR_EN]};
    if (WR) begin
      unique case (wa)
        `PCB_OFS_CMD: begin
          cmd_nxt = merge(cmd_r, WDATA, BE, `PCB_MSK_CMD);
          if (BE[3]) begin
            sts_clr = {WDATA[`PCB_STS_PERR], WDATA[`PCB_STS_SERR], WDATA[`PCB_STS_MABT],
                       WDATA[`PCB_STS_TABT], WDATA[`PCB_STS_DPR]};
          end
        end
        `PCB_OFS_LAT: lat_nxt = merge(lat_r, WDATA, BE, `PCB_MSK_LAT);
        `PCB_OFS_IO: io_nxt = merge(io_r, WDATA, BE, `PCB_MSK_IO);
        `PCB_OFS_MEM: mem_nxt = merge(mem_r, WDATA, BE, `PCB_MSK_MEM);
        `PCB_OFS_ROM: rom_nxt = merge(rom_r, WDATA, BE, `PCB_MSK_ROM);
        `PCB_OFS_INT: int_nxt = merge(int_r, WDATA, BE, `PCB_MSK_INT);
        `PCB_OFS_SCRATCH: scratch_nxt = merge(scratch_r, WDATA, BE, `PCB_MSK_SCRATCH);
        `PCB_OFS_PMCS: pmcs_nxt = merge(pmcs_r, WDATA, BE, `PCB_MSK_PMCS);
        default: begin
          // ID, signature and unmapped words ignore writes
          cmd_nxt = cmd_r;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    sts_nxt = (sts_r & ~sts_clr) | sts_set;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= `PCB_ZERO;
      lat_r <= `PCB_ZERO;
      io_r <= `PCB_ZERO;
      mem_r <= `PCB_ZERO;
      rom_r <= `PCB_ZERO;
      int_r <= `PCB_ZERO;
      scratch_r <= `PCB_ZERO;
      pmcs_r <= `PCB_ZERO;
      sts_r <= 5'h0;
      CMD <= 16'h0;
      PM_STATE <= 2'h0;
    end else begin
      cmd_r <= cmd_nxt;
      lat_r <= lat_nxt;
      io_r <= io_nxt;
      mem_r <= mem_nxt;
      rom_r <= rom_nxt;
      int_r <= int_nxt;
      scratch_r <= scratch_nxt;
      pmcs_r <= pmcs_nxt;
      sts_r <= sts_nxt;
      CMD <= cmd_nxt[15:0];
      PM_STATE <= pmcs_nxt[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; data stand one cycle, zero otherwise
  pcb_word_t rd_nxt, sts_word;

  always_comb begin
    sts_word = `PCB_ZERO;
    sts_word[31:16] = `PCB_STS_FIXED;
    sts_word[`PCB_STS_NEWCAP] = NEW_CAP;
    sts_word[`PCB_STS_PERR] = sts_r[4];
    sts_word[`PCB_STS_SERR] = sts_r[3];
    sts_word[`PCB_STS_MABT] = sts_r[2];
    sts_word[`PCB_STS_TABT] = sts_r[1];
    sts_word[`PCB_STS_DPR] = sts_r[0];
    rd_nxt = `PCB_ZERO;
    if (RD) begin
      unique case (wa)
        `PCB_OFS_ID: rd_nxt = {dev_r, ven_r};
        `PCB_OFS_CMD: rd_nxt = sts_word | cmd_r;
        `PCB_OFS_CLASS: rd_nxt = {CLASS_CODE, REV_STEP};
        `PCB_OFS_LAT: rd_nxt = lat_r;
        `PCB_OFS_IO: rd_nxt = io_r | `PCB_IO_IND;
        `PCB_OFS_MEM: rd_nxt = mem_r;
        `PCB_OFS_SUB: rd_nxt = {sub_r, subv_r};
        `PCB_OFS_ROM: rd_nxt = rom_r;
        `PCB_OFS_CAPP: rd_nxt = {24'h0, `PCB_OFS_PMC};
        `PCB_OFS_INT: rd_nxt = {mlat_r, mgnt_r, `PCB_INT_PIN, int_r[7:0]};
        `PCB_OFS_SCRATCH: rd_nxt = scratch_r;
        `PCB_OFS_FPRINT: rd_nxt = SIGNATURE;
        `PCB_OFS_PMC: rd_nxt = {PM_CAPS, `PCB_NEXT_PTR, `PCB_CAP_ID};
        `PCB_OFS_PMCS: rd_nxt = pmcs_r;
        default: rd_nxt = `PCB_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= `PCB_ZERO;
    end else begin
      RDATA <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // ID read check uses past state; a load may land mid-read
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  AST_ID_LAYOUT: assert property (RD && wa == `PCB_OFS_ID |=>
    RDATA == {$past(dev_r), $past(ven_r)}) else $error("ID word layout wrong");
  AST_ID_RO: assert property (WR && wa == `PCB_OFS_ID && ld_r == LD_DONE |=>
    $stable(dev_r) && $stable(ven_r)) else $error("ID changed by write");
  AST_LOAD: assert property (ld_r == LD_FETCH && EE_ACK |=>
    LOAD_DONE && !EE_REQ && dev_r == $past(EE_DEV_ID) && mgnt_r == $past(EE_MIN_GNT))
    else $error("EEPROM load not captured");
  AST_PERR: assert property (PERR_DET |=> sts_r[4] ##1
    (sts_r[4] || $past(WR && wa == `PCB_OFS_CMD && BE[3] && WDATA[31])))
    else $error("Parity flag not set");
  AST_FPRINT: assert property (WR && wa == `PCB_OFS_FPRINT ##[1:2]
    RD && wa == `PCB_OFS_FPRINT |=> RDATA == SIGNATURE) else $error("Signature not hardwired");
  AST_SCRATCH_WR: assert property (WR && wa == `PCB_OFS_SCRATCH && BE[1] |=>
    scratch_r[15:8] == $past(WDATA[15:8]) && scratch_r[7:0] == 8'h0)
    else $error("Scratch write lost");
  AST_LANE: assert property (WR && wa == `PCB_OFS_LAT && !BE[1] |=>
    lat_r[15:8] == $past(lat_r[15:8])) else $error("Disabled lane written");
  AST_ROM: assert property (WR && wa == `PCB_OFS_ROM |=>
    rom_r[16:1] == 16'h0) else $error("ROM window not 128 KB");
  AST_CAPP: assert property (RD && wa == `PCB_OFS_CAPP |=>
    RDATA == 32'h0000_00c0) else $error("Capability pointer wrong");
  AST_RES: assert property (RD && wa == 8'h18 |=> RDATA == `PCB_ZERO ##1
    ($past(RD) || RDATA == `PCB_ZERO)) else $error("Reserved word not zero");
  AST_CLASS: assert property (RD && wa == `PCB_OFS_CLASS |=>
    RDATA[31:8] == CLASS_CODE && RDATA[7:0] == REV_STEP) else $error("Class word wrong");
  AST_PMCS: assert property (RD && wa == `PCB_OFS_PMCS |=>
    RDATA[31:16] == 16'h0) else $error("PM upper half not zero");
  AST_PMC: assert property (RD && wa == `PCB_OFS_PMC |=>
    RDATA[7:0] == `PCB_CAP_ID && RDATA[31:16] == PM_CAPS) else $error("PM capability wrong");
  AST_RD_IDLE: assert property (!RD |=> RDATA == `PCB_ZERO)
    else $error("Read data not idle");
  AST_LOAD_HOLD: assert property (LOAD_DONE |=> LOAD_DONE && !EE_REQ)
    else $error("Load state lost");
  AST_DPR_OFF: assert property (PERR_DET && !(BUS_MASTER && cmd_r[`PCB_CMD_PERR_EN]) &&
    !sts_r[0] |=> !sts_r[0]) else $error("Parity report set without enable");

  COV_LOAD: cover property (ld_r == LD_FETCH ##1 EE_ACK ##1 LOAD_DONE);
  COV_BYTE_WR: cover property (WR && wa == `PCB_OFS_SCRATCH && BE == 4'h2);
  COV_PERR_CLR: cover property (sts_r[4] ##1 WR && wa == `PCB_OFS_CMD && WDATA[31]);
  COV_BACK2BACK: cover property (WR ##1 RD);
  COV_SET_CLR: cover property (PERR_DET && WR && wa == `PCB_OFS_CMD && BE[3] && WDATA[31]);

endmodule
`default_nettype wire

// ==== tb/pcb_ee_model.sv ====
// Purpose: serial EEPROM loader model feeding the bank
// Assumes: one load per reset, answer after DELAY cycles
// Notes: data lines show inverted values outside the ack cycle
`timescale 1ns/1ps
`default_nettype none
module pcb_ee_model #(
  parameter int DELAY = 3,
  // Arbitrary identity values
  parameter logic [15:0] DEV = 16'h2222,
  parameter logic [15:0] VEN = 16'h1111,
  parameter logic [15:0] SUB = 16'h3333,
  parameter logic [15:0] SUBVEN = 16'h4444,
  parameter logic [7:0] MLAT = 8'h55,
  parameter logic [7:0] MGNT = 8'h66
) (
  input wire logic clk,
  input wire logic ee_req,
  output logic ee_ack,
  output logic [15:0] dev_id,
  output logic [15:0] ven_id,
  output logic [15:0] sub_id,
  output logic [15:0] subven_id,
  output logic [7:0] max_lat,
  output logic [7:0] min_gnt
);
  logic [7:0] cnt_r = 8'h00;
  logic ack_r = 1'b0;
  ////////////////////////////////////////////////////////////////
  // One-cycle ack; slow answer exposes early sampling
  always_ff @(posedge clk) begin
    cnt_r <= ee_req ? cnt_r + 8'h01 : 8'h00;
    ack_r <= ee_req && !ack_r && (cnt_r == 8'(DELAY));
  end
  assign ee_ack = ack_r;
  assign dev_id = ack_r ? DEV : ~DEV;
  assign ven_id = ack_r ? VEN : ~VEN;
  assign sub_id = ack_r ? SUB : ~SUB;
  assign subven_id = ack_r ? SUBVEN : ~SUBVEN;
  assign max_lat = ack_r ? MLAT : ~MLAT;
  assign min_gnt = ack_r ? MGNT : ~MGNT;
endmodule
`default_nettype wire

// ==== tb/pcb_cfg_bank_tb_top.sv ====
// Purpose: self-checking bench of the configuration bank
// Assumes: loader model answers after reset release
// Notes: expectations follow the register masks and parameters
`timescale 1ns/1ps
`default_nettype none
module pcb_cfg_bank_tb_top;
  import pcb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  pcb_word_t wdata = 32'h0000_0000;
  pcb_word_t rdata;
  pcb_word_t got;
  logic [3:0] be = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic perr = 1'b0;
  logic serr = 1'b0;
  logic mabt = 1'b0;
  logic tabt = 1'b0;
  logic bm = 1'b1;
  logic ee_ack, ee_req, load_done;
  logic [15:0] dev, ven, sub, subven, cmd;
  logic [7:0] mlat, mgnt;
  logic [1:0] pm_state;
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] ta [15] = '{8'h0c, 8'h10, 8'h14, 8'h30, 8'h40, 8'h80, 8'hc4, 8'h00,
                          8'h08, 8'hc0, 8'h34, 8'h18, 8'h2c, 8'h3c, 8'h38};
  pcb_word_t te [15] = '{32'h0000_ffff, 32'hffff_ff01, 32'hffff_ff00, 32'hfffe_0001,
                         32'h0000_ff00, 32'h5a5a_0001, 32'h0000_0103, 32'h2222_1111,
                         32'h0200_0000, 32'h0002_0001, 32'h0000_00c0, 32'h0000_0000,
                         32'h3333_4444, 32'h5566_01ff, 32'h0000_0000};
  ////////////////////////////////////////////////////////////////
  pcb_cfg_bank i_pcb_cfg_bank (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
    .BE(be), .WR(wr), .RD(rd), .RDATA(rdata), .EE_ACK(ee_ack), .EE_DEV_ID(dev),
    .EE_VEN_ID(ven), .EE_SUB_ID(sub), .EE_SUBVEN_ID(subven), .EE_MAX_LAT(mlat),
    .EE_MIN_GNT(mgnt), .EE_REQ(ee_req), .LOAD_DONE(load_done), .PERR_DET(perr),
    .SERR_DRV(serr), .MABT_DET(mabt), .TABT_DET(tabt), .BUS_MASTER(bm), .CMD(cmd),
    .PM_STATE(pm_state));
  pcb_ee_model i_pcb_ee_model (.clk(clk), .ee_req(ee_req), .ee_ack(ee_ack),
    .dev_id(dev), .ven_id(ven), .sub_id(sub), .subven_id(subven), .max_lat(mlat),
    .min_gnt(mgnt));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input pcb_word_t seen, input pcb_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input pcb_word_t d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output pcb_word_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 100 && load_done !== 1'b1; i++) @(posedge clk);
    chk({31'h0, load_done}, 32'h1);
    chk({31'h0, ee_req}, 32'h0);
  endtask
  task automatic pulse(input logic [3:0] ev);
    @(posedge clk);
    {perr, serr, mabt, tabt} <= ev;
    @(posedge clk);
    {perr, serr, mabt, tabt} <= 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_table();
    for (int i = 0; i < 15; i++) begin
      wr_reg(ta[i], 32'hffff_ffff, 4'hf);
      rd_reg(ta[i], got);
      chk(got, te[i]);
    end
    chk({30'h0, pm_state}, 32'h3);
  endtask
  task automatic t_lanes();
    wr_reg(8'h40, 32'h0000_ab00, 4'h2);
    wr_reg(8'h40, 32'h0000_cd00, 4'h1);
    rd_reg(8'h40, got);
    chk(got, 32'h0000_ab00);
    wr_reg(8'h10, 32'h1234_5678, 4'h4);
    rd_reg(8'h10, got);
    chk(got, 32'hff34_ff01);
    wr_reg(8'h0c, 32'h0000_1234, 4'h1);
    rd_reg(8'h0c, got);
    chk(got, 32'h0000_ff34);
  endtask
  task automatic t_status();
    pulse(4'h8);
    rd_reg(8'h04, got);
    chk(got, 32'h8290_0000);
    wr_reg(8'h04, 32'h0000_ffff, 4'h3);
    // Output settles after the write edge
    #1 chk({16'h0, cmd}, 32'h0000_0147);
    pulse(4'h8);
    pulse(4'h7);
    rd_reg(8'h04, got);
    chk(got, 32'hf390_0147);
    wr_reg(8'h04, 32'hff00_0000, 4'h8);
    rd_reg(8'h04, got);
    chk(got, 32'h0290_0147);
    // Set beats a clear in the same cycle
    @(posedge clk);
    {perr, serr, mabt, tabt} <= 4'h8;
    addr <= 8'h04;
    wdata <= 32'hff00_0000;
    be <= 4'h8;
    wr <= 1'b1;
    @(posedge clk);
    {perr, serr, mabt, tabt} <= 4'h0;
    wr <= 1'b0;
    rd_reg(8'h04, got);
    chk(got, 32'h8390_0147);
  endtask
  // Hard reset mid-run must bring defaults back
  task automatic t_hard_reset();
    do_reset();
    rd_reg(8'h40, got);
    chk(got, 32'h0000_0000);
    rd_reg(8'h30, got);
    chk(got, 32'h0000_0000);
    chk({16'h0, cmd}, 32'h0000_0000);
    rd_reg(8'h00, got);
    chk(got, 32'h2222_1111);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  initial begin
    do_reset();
    t_table();
    t_lanes();
    t_status();
    t_hard_reset();
    end_sim();
  end
endmodule
`default_nettype wire
